// ==== rtl/tcp_pkg.sv ====
package tcp_pkg;

  // system clock, also the high-frequency clock of the timer
  localparam int unsigned TCP_CLK_HZ     = 25_000_000;

  // register indices; the byte address is four times the index
  localparam logic [7:0]  TCP_IDX_CONTROL = 8'h1a;
  localparam logic [7:0]  TCP_IDX_COMPARE = 8'h1b;
  localparam logic [7:0]  TCP_IDX_STATUS  = 8'h1c;

  // timer_control field positions
  localparam int unsigned TCP_MODE_LSB   = 0;
  localparam int unsigned TCP_CKSEL_LSB  = 2;
  localparam int unsigned TCP_RUN_BIT    = 5;

  // status register field positions
  localparam int unsigned TCP_ST_CNT_LSB = 0;
  localparam int unsigned TCP_ST_DIV_BIT = 8;
  localparam int unsigned TCP_ST_PWM_BIT = 9;
  localparam int unsigned TCP_ST_ACT_LSB = 16;

  // reset values and the counter top value
  localparam logic [7:0]  TCP_CONTROL_RST = 8'h00;
  localparam logic [7:0]  TCP_COMPARE_RST = 8'hff;
  localparam logic [7:0]  TCP_CNT_MAX     = 8'hff;

  // clock select code for rising edges on the event pin
  localparam logic [2:0]  TCP_CK_EXT     = 3'b111;

  // log2 of the prescaler divisor per clock select code, gear bit clear
  localparam logic [3:0]  TCP_CK_EXP [7] = '{4'hb, 4'h7, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam int unsigned TCP_PRESC_W    = 13;

  typedef enum logic [1:0] {
    TCP_MODE_TIMER = 2'b00,
    TCP_MODE_RSVD  = 2'b01,
    TCP_MODE_DIV   = 2'b10,
    TCP_MODE_PWM   = 2'b11
  } tcp_mode_type;

  typedef enum logic [1:0] {
    TCP_SEL_NONE    = 2'b00,
    TCP_SEL_CONTROL = 2'b01,
    TCP_SEL_COMPARE = 2'b10,
    TCP_SEL_STATUS  = 2'b11
  } tcp_sel_type;

  // address decode, shared by the read answer and the write strobe
  function automatic tcp_sel_type tcp_reg_sel(input logic [7:0] addr);
    tcp_sel_type sel;
    sel = TCP_SEL_NONE;
    if (addr == {TCP_IDX_CONTROL[5:0], 2'b00}) sel = TCP_SEL_CONTROL;
    if (addr == {TCP_IDX_COMPARE[5:0], 2'b00}) sel = TCP_SEL_COMPARE;
    if (addr == {TCP_IDX_STATUS[5:0], 2'b00})  sel = TCP_SEL_STATUS;
    return sel;
  endfunction

  // prescaler exponent for a clock code, doubled divisor with the gear bit
  function automatic logic [3:0] tcp_ck_exp(input logic [2:0] code, input logic gear);
    logic [3:0] e;
    e = (code == TCP_CK_EXT) ? 4'h0 : TCP_CK_EXP[code];
    return e + {3'b000, gear};
  endfunction

endpackage

// ==== rtl/tcp_prescaler.sv ====
`timescale 1ns/10ps
module tcp_prescaler
  import tcp_pkg::*;
#(
  parameter int unsigned DIV_W = TCP_PRESC_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [3:0] exp_sel,
  output logic            tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } tcp_presc_type;

  tcp_presc_type    q;
  tcp_presc_type    d;
  logic [DIV_W-1:0] mask;

  if (DIV_W < 13 || DIV_W > 16) begin : g_chk
    $error("prescaler width must cover a divisor of 2^12");
  end

  // mask of the low counter bits that must all be one for a tick
  for (genvar i = 0; i < DIV_W; i++) begin : g_mask
    assign mask[i] = (i < exp_sel);
  end

  // divisor 1 gives a tick every cycle because the mask is empty
  assign tick = run && ((q.cnt & mask) == mask);

  // held at zero while stopped so the first period after start is whole
  always_comb begin
    d = q;
    if (run) begin
      d.cnt = q.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end else begin
      d.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ==== rtl/tcp_pin_sync.sv ====
`timescale 1ns/10ps
module tcp_pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tcp_sync_type;

  tcp_sync_type q;
  tcp_sync_type d;
  logic         agree;

  // the first stage feeds the second only; a change counts once s2 and s3 agree
  assign agree = (q.s2 == q.s3);
  assign rise  = agree && q.s3 && !q.lvl;
  assign fall  = agree && !q.s3 && q.lvl;

  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (agree) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ==== rtl/tcp_timer.sv ====
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// R1 - run bit low stops and zeroes the counter; setting it starts from zero
// R2 - clock select 000..110 picks a prescaled clock, gear doubles; 111 picks pin edges
// R3 - mode field 00 timer or event counter, 10 divider output, 11 pwm, 01 reserved
// R4 - software keeps the compare value between 1 and 255
// R5 - software changes mode and clock only while stopped, not with run changes
// R6 - entering stop power mode clears the run bit and halts counting
// R7 - control register bits 7 and 6 read as don't care
// R8 - software leaves compare alone while running in timer, event or divider mode
// R9 - software avoids the undivided clock above 10 MHz
// R10 - software uses only the clock codes allowed for each mode
// R11 - timer mode: count internal clock, on match interrupt and clear, keep counting
// R12 - event mode: count pin rises, check match at next fall, interrupt and clear
// R13 - event pulses stay high and low longer than two machine cycles
// R14 - event and pwm modes only in normal or idle power modes
// R15 - divider mode: each match toggles output, interrupts and clears the counter
// R16 - divider output is high whenever stopped
// R17 - pwm mode: match drives pwm output low, counter keeps going
// R18 - pwm mode: overflow drives output high and interrupts; period 256 clocks
// R19 - pwm output is high whenever stopped
// R20 - pwm mode: compare writes go to a buffer, moved in at cycle end
// R21 - pwm mode: starting the timer moves the buffered compare in at once
// R22 - software rewrites compare right after the interrupt in pwm mode
// R23 - counter is 8 bits and wraps from ff to 00
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_input_pin,
  input  wire logic        clock_gear_bit,
  input  wire logic        stop_entry,
  output logic             timer_irq,
  output logic             divider_out_pin,
  output logic             pwm_out_n_pin
);

  typedef struct packed {
    logic         run;
    tcp_mode_type mode;
    logic [2:0]   cksel;
    logic [7:0]   cmp_buf;
    logic [7:0]   cmp_act;
    logic [7:0]   cnt;
    logic         div_out;
    logic         pwm_n;
    logic         irq;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } tcp_state_type;

  tcp_state_type q;
  tcp_state_type d;
  logic          ev_rise;
  logic          ev_fall;
  logic          presc_tick;
  logic          presc_run;
  logic          ext_src;
  logic          tick;
  logic          setup;
  logic          wr;
  logic [7:0]    cnt_inc;
  logic [7:0]    cmp_now;
  tcp_sel_type   sel;

  if (CNT_W != 8) begin : g_chk
    $error("the counter and compare stage are fixed at 8 bits");
  end

  // event pin comes from outside: three stages before it may count
  tcp_pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (event_input_pin),
    .rise    (ev_rise),
    .fall    (ev_fall)
  );

  // prescaled internal clock; idle when the pin is the source
  assign ext_src   = (q.cksel == TCP_CK_EXT);
  assign presc_run = q.run && !ext_src;

  tcp_prescaler u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (presc_run),
    .exp_sel (tcp_ck_exp(q.cksel, clock_gear_bit)),
    .tick    (presc_tick)
  );

  // source clock enable: pin edges or a prescaler tick
  assign tick    = ext_src ? ev_rise : presc_tick; // see R2
  assign cnt_inc = q.cnt + 8'h01;                   // see R23

  // pwm compares against the active stage, the other modes against the register
  assign cmp_now = (q.mode == TCP_MODE_PWM) ? q.cmp_act : q.cmp_buf;

  // apb phases: answer is prepared in setup, write lands at the access edge
  assign setup = psel && !penable;
  assign wr    = psel && penable && q.pready && pwrite && pstrb[0];
  assign sel   = tcp_reg_sel(paddr);

  always_comb begin
    d         = q;
    d.irq     = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // read answer and error flag, registered so the bus sees flop outputs
    if (setup) begin
      d.pready  = 1'b1;
      d.pslverr = (sel == TCP_SEL_NONE);
      d.prdata  = 32'h0000_0000;
      unique case (sel)
        TCP_SEL_CONTROL: begin
          // top two bits are don't care, they read as zero here
          d.prdata[TCP_RUN_BIT]         = q.run;  // see R7
          d.prdata[TCP_CKSEL_LSB +: 3]  = q.cksel;
          d.prdata[TCP_MODE_LSB +: 2]   = q.mode;
        end
        TCP_SEL_COMPARE: begin
          d.prdata[7:0] = q.cmp_buf;
        end
        TCP_SEL_STATUS: begin
          d.prdata[TCP_ST_CNT_LSB +: 8] = q.cnt;
          d.prdata[TCP_ST_DIV_BIT]      = q.div_out;
          d.prdata[TCP_ST_PWM_BIT]      = q.pwm_n;
          d.prdata[TCP_ST_ACT_LSB +: 8] = q.cmp_act;
        end
        TCP_SEL_NONE: begin
          d.prdata = 32'h0000_0000;
        end
      endcase
    end

    // register writes; status is read only and ignores writes
    if (wr) begin
      unique case (sel)
        TCP_SEL_CONTROL: begin
          d.run   = pwdata[TCP_RUN_BIT];
          d.cksel = pwdata[TCP_CKSEL_LSB +: 3];             // see R2
          d.mode  = tcp_mode_type'(pwdata[TCP_MODE_LSB +: 2]); // see R3
        end
        TCP_SEL_COMPARE: begin
          // in pwm mode this is only the buffer stage
          d.cmp_buf = pwdata[7:0]; // see R20
        end
        TCP_SEL_STATUS: begin
          d.cmp_buf = q.cmp_buf;
        end
        TCP_SEL_NONE: begin
          d.cmp_buf = q.cmp_buf;
        end
      endcase
    end

    // power-down entry beats a software start in the same cycle
    if (stop_entry) begin
      d.run = 1'b0; // see R6
    end

    if (!d.run) begin
      // stopped: counter clear, both outputs parked high
      d.cnt     = 8'h00;  // see R1
      d.div_out = 1'b1;   // see R16
      d.pwm_n   = 1'b1;   // see R19
    end else if (!q.run) begin
      // first cycle of a run: start from zero and load the pwm stage
      d.cnt = 8'h00; // see R1
      if (d.mode == TCP_MODE_PWM) begin
        d.cmp_act = d.cmp_buf; // see R21
      end
    end else begin
      unique case (q.mode)
        TCP_MODE_TIMER: begin
          if (ext_src) begin
            // event counter: rises count, the match is judged on the fall
            if (ev_rise) begin
              d.cnt = cnt_inc; // see R12
            end
            if (ev_fall && q.cnt == cmp_now) begin
              d.cnt = 8'h00; // see R12
              d.irq = 1'b1;
            end
          end else if (tick) begin
            if (cnt_inc == cmp_now) begin
              d.cnt = 8'h00; // see R11
              d.irq = 1'b1;
            end else begin
              d.cnt = cnt_inc; // see R11
            end
          end
        end
        TCP_MODE_DIV: begin
          // each match flips the output, so the period is two matches
          if (tick) begin
            if (cnt_inc == cmp_now) begin
              d.cnt     = 8'h00;      // see R15
              d.div_out = !q.div_out; // see R15
              d.irq     = 1'b1;
            end else begin
              d.cnt = cnt_inc;
            end
          end
        end
        TCP_MODE_PWM: begin
          // free-running over 256 ticks; the match only lowers the output
          if (tick) begin
            d.cnt = cnt_inc; // see R17
            if (q.cnt == TCP_CNT_MAX) begin
              d.pwm_n   = 1'b1;      // see R18
              d.irq     = 1'b1;      // see R18
              d.cmp_act = q.cmp_buf; // see R20
            end else if (cnt_inc == cmp_now) begin
              d.pwm_n = 1'b0; // see R17
            end
          end
        end
        TCP_MODE_RSVD: begin
          // reserved code: the counter simply holds
          d.cnt = q.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.cmp_buf <= TCP_COMPARE_RST;
      q.cmp_act <= TCP_COMPARE_RST;
      q.div_out <= 1'b1;
      q.pwm_n   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // every output is a flop of the state
  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign timer_irq       = q.irq;
  assign divider_out_pin = q.div_out;
  assign pwm_out_n_pin   = q.pwm_n;

endmodule

// ==== dv/tcp_timer_assertions.sv ====
`timescale 1ns/10ps
module tcp_timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        stop_entry,
  input wire logic        timer_irq,
  input wire logic        divider_out_pin,
  input wire logic        pwm_out_n_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic stop_wr;
  // a control write landing with the run bit low
  assign stop_wr = psel && penable && pready && pwrite && pstrb[0] && paddr == 8'h68 && !pwdata[5];
  property p_setup_ready;
    psel && !penable |=> pready;
  endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
  property p_err_map;
    pready && !(paddr inside {8'h68, 8'h6c, 8'h70}) |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_ctl_top;
    pready && !pwrite && paddr == 8'h68 |-> prdata[31:6] == 26'h000_0000;
  endproperty
  a_ctl_top: assert property (p_ctl_top) else $error("control top bits not zero");
  property p_stop_pins;
    stop_wr |-> ##2 (divider_out_pin && pwm_out_n_pin);
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("pins low after stop");
  property p_stop_entry;
    stop_entry |-> ##2 (divider_out_pin && pwm_out_n_pin);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("power-down did not stop");
  property p_div_fall;
    $fell(divider_out_pin) |-> timer_irq;
  endproperty
  a_div_fall: assert property (p_div_fall) else $error("divider toggle without irq");
  property p_irq_pulse;
    timer_irq |=> !timer_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
  property p_pwm_fall;
    $fell(pwm_out_n_pin) |-> !timer_irq;
  endproperty
  a_pwm_fall: assert property (p_pwm_fall) else $error("irq on pwm match");
endmodule

// ==== dv/tcp_event_src.sv ====
`timescale 1ns/10ps
module tcp_event_src (
  input  wire logic pclk,
  output logic      event_input_pin
);
  // line idles low between bursts
  initial event_input_pin = 1'b0;
  // ten clocks per phase keeps well clear of the minimum pulse width
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (10) @(posedge pclk);
      event_input_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      event_input_pin <= 1'b0;
    end
  endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import tcp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic        event_input_pin, clock_gear_bit, stop_entry;
  logic        timer_irq, divider_out_pin, pwm_out_n_pin;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, total_checks, per, low, dv, n_irq, base;
  localparam logic [7:0] A_CTL = {TCP_IDX_CONTROL[5:0], 2'b00};
  localparam logic [7:0] A_CMP = {TCP_IDX_COMPARE[5:0], 2'b00};
  localparam logic [7:0] A_STS = {TCP_IDX_STATUS[5:0], 2'b00};
  // per run: control, compare, gear mask, legal clocks only divisor exponents
  localparam logic [7:0] T_CTL [8] = '{8'h0c, 8'h0c, 8'h00, 8'h04, 8'h0a, 8'h0f, 8'h13, 8'h17};
  localparam logic [7:0] T_CMP [8] = '{8'h01, 8'hff, 8'h01, 8'h03, 8'h03, 8'h80, 8'h01, 8'h40};
  localparam logic [7:0] T_GR  = 8'h44;
  localparam int         T_EXP [7] = '{11, 7, 5, 3, 2, 1, 0};

  tcp_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .event_input_pin, .clock_gear_bit, .stop_entry,
    .timer_irq, .divider_out_pin, .pwm_out_n_pin);
  tcp_event_src u_src (.pclk, .event_input_pin);

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // interrupt tally for the event scenario
  always @(posedge pclk) n_irq <= n_irq + (timer_irq === 1'b1);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    do begin @(posedge pclk); t++; end while (timer_irq !== 1'b1 && t < 20000);
    // a missing interrupt is a mismatch, not a silent fall-through
    if (timer_irq !== 1'b1) err_total++;
  endtask
  // clocks over n irq intervals and clocks with either pin low
  task automatic measure(input int n, output int cyc, output int lo);
    int k;
    cyc = 0;
    lo = 0;
    k = 0;
    while (k < n && cyc < 30000) begin
      @(posedge pclk);
      cyc++;
      lo += (pwm_out_n_pin === 1'b0 || divider_out_pin === 1'b0) ? 1 : 0;
      if (timer_irq === 1'b1) k++;
    end
    if (k < n) err_total++;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard, about half again the expected run of some 43000 clocks
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, clock_gear_bit, stop_entry} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // unmapped write is refused and leaves the registers at reset
    apb(1'b1, 8'h74, 32'h0000_0000);
    check(errv, 1'b1);
    apb(1'b0, A_CTL, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, A_CMP, 32'h0000_0000);
    check(rd, 32'h0000_00ff);
    // each mode with its allowed clocks, fields set only while stopped
    for (int i = 0; i < 8; i++) begin
      clock_gear_bit <= T_GR[i];
      apb(1'b1, A_CTL, {24'h00_0000, T_CTL[i]});
      apb(1'b1, A_CMP, {24'h00_0000, T_CMP[i]});
      apb(1'b1, A_CTL, {24'h00_0000, T_CTL[i] | 8'h20});
      dv = 1 << (T_EXP[T_CTL[i][4:2]] + T_GR[i]);
      wait_irq();
      measure(2, per, low);
      if (T_CTL[i][1:0] == 2'b11) begin
        check(per, 512 * dv);
        check(low, 2 * (256 - T_CMP[i]) * dv);
      end else begin
        check(per, 2 * T_CMP[i] * dv);
        check(low, T_CTL[i][1] * T_CMP[i] * dv);
      end
      apb(1'b1, A_CTL, {24'h00_0000, T_CTL[i]});
      apb(1'b0, A_STS, 32'h0000_0000);
      check(rd & 32'h0000_03ff, 32'h0000_0300);
    end
    // a compare rewrite right after the irq waits for the cycle end
    apb(1'b1, A_CTL, 32'h0000_000f);
    apb(1'b1, A_CMP, 32'h0000_0040);
    apb(1'b1, A_CTL, 32'h0000_002f);
    wait_irq();
    apb(1'b1, A_CMP, 32'h0000_00c0);
    measure(1, per, low);
    check(low, (256 - 64) * 8);
    measure(1, per, low);
    check(low, (256 - 192) * 8);
    repeat (1800) @(posedge pclk);
    apb(1'b1, A_CTL, 32'h0000_000f);
    // event counting: match flagged at the fall after the third rise
    apb(1'b1, A_CTL, 32'h0000_001c);
    apb(1'b1, A_CMP, 32'h0000_0003);
    apb(1'b1, A_CTL, 32'h0000_003c);
    base = n_irq;
    u_src.send(2);
    repeat (10) @(posedge pclk);
    check(n_irq - base, 0);
    u_src.send(1);
    repeat (10) @(posedge pclk);
    check(n_irq - base, 1);
    u_src.send(3);
    repeat (10) @(posedge pclk);
    check(n_irq - base, 2);
    // power-down entry in divider mode, with the pin low, clears run and parks the pin
    apb(1'b1, A_CTL, 32'h0000_001c);
    apb(1'b1, A_CTL, 32'h0000_000a);
    apb(1'b1, A_CTL, 32'h0000_002a);
    wait_irq();
    check(divider_out_pin, 1'b0);
    stop_entry <= 1'b1;
    @(posedge pclk);
    stop_entry <= 1'b0;
    apb(1'b0, A_CTL, 32'h0000_0000);
    check(rd, 32'h0000_000a);
    apb(1'b0, A_STS, 32'h0000_0000);
    check(rd & 32'h0000_03ff, 32'h0000_0300);
    give_verdict();
  end
endmodule

bind tcp_timer tcp_timer_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .stop_entry, .timer_irq, .divider_out_pin,
  .pwm_out_n_pin);
